//--- logic/pas_consts.svh
// Constants for the positioner alarm summary block
`ifndef PAS_CONSTS_SVH
`define PAS_CONSTS_SVH

// Clock rate and timing figures
`define PAS_CLK_HZ          100000000
`define PAS_BLOCK_ALARM_S   10
`define PAS_TIME_UNIT_MS    10
`define PAS_GAIN_SETTLE_MS  1

// Position scale: 0.01 % per lsb, full travel = 100.00 %
`define PAS_POS_ZERO        16'h0000
`define PAS_POS_FULL        16'h2710
// T63 fraction as x/256 (161/256 = 0.629)
`define PAS_T63_NUM         9'hA1
`define PAS_T63_SHIFT       8

// Digest layout: element 1 in bits 63:48, byte 1 in bits 63:56
`define PAS_DIGEST_W        64
`define PAS_BIT_BLOCK_ALARM 7
`define PAS_BIT_POS_LOW     4
`define PAS_BIT_POS_LOLO    3
`define PAS_BIT_POS_HIGH    2
`define PAS_BIT_POS_HIHI    1

// Reset values and limits
`define PAS_RST_DIGEST      64'h0000_0000_0000_0000
`define PAS_RST_TIME        16'h0000
`define PAS_RST_GAIN        3'h0
`define PAS_GAIN_MAX        3'h7
`define PAS_TIME_SAT        16'hFFFF

`endif

//--- logic/pas_pkg.sv
// Types for the positioner alarm summary block
package pas_pkg;

  typedef enum logic [1:0] {
    PAS_KIND_FUNCTION   = 2'h0,
    PAS_KIND_TRANSDUCER = 2'h1,
    PAS_KIND_PHYSICAL   = 2'h2
  } pas_kind_t;

  typedef enum logic [2:0] {
    PAS_ST_IDLE      = 3'h0,
    PAS_ST_GAIN_WAIT = 3'h1,
    PAS_ST_GAIN_STEP = 3'h2,
    PAS_ST_OPEN_RUN  = 3'h3,
    PAS_ST_CLOSE_RUN = 3'h4
  } pas_state_t;

endpackage

//--- logic/pas_hyst_flag.sv
// One position alarm flag with hysteresis on its clearing edge
`timescale 1ns/10ps
`default_nettype none

module pas_hyst_flag #(
  parameter bit HIGH_SIDE = 1'b1
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_enable,
  input  wire logic [15:0] i_position,
  input  wire logic [15:0] i_threshold,
  input  wire logic [15:0] i_hysteresis,
  output logic             o_flag
);

  logic        flag_q;
  logic        flag_d;
  logic [16:0] band;

  // Set while beyond the threshold; clear only once back past the band
  always_comb begin
    flag_d = flag_q;
    band   = 17'h00000;
    if (!i_enable) begin
      flag_d = 1'b0;
    end else if (HIGH_SIDE) begin
      band = {1'b0, i_position} + {1'b0, i_hysteresis};
      if (i_position >= i_threshold) begin
        flag_d = 1'b1;
      end else if (band < {1'b0, i_threshold}) begin
        flag_d = 1'b0;
      end
    end else begin
      band = {1'b0, i_threshold} + {1'b0, i_hysteresis};
      if (i_position <= i_threshold) begin
        flag_d = 1'b1;
      end else if ({1'b0, i_position} > band) begin
        flag_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule

`default_nettype wire

//--- logic/pas_alarm_summary.sv
// Positioner alarm summary word and autostart calibration capture
// What this block does
// - Summary is four elements of two bytes each, sixty-four bits.
// - Only element one holds live alarms; elements two to four read zero.
// - Each position bit sets while its condition is true and clears only once past the hysteresis band.
// - Bit seven of byte one sets when the static revision counter increments.
// - The block-alarm bit clears itself ten seconds after being set.
// - Bit4 low, bit3 low-low, bit2 high, bit1 high-high; 6,5,0 reserved.
// - Position bits only in function block kind; otherwise always zero.
// - Second byte of element one is reserved and reads zero.
// - Configurable hysteresis applies to all four position alarm bits.
// - Autostart measures minimum closing time toward zero as T63 value.
// - Autostart measures minimum opening time toward full travel as T63 value.
// - Autostart finds converter gain and keeps it for later measurements.
`include "pas_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module pas_alarm_summary #(
  parameter int unsigned BLOCK_ALARM_CYCLES = `PAS_BLOCK_ALARM_S * `PAS_CLK_HZ,
  parameter int unsigned TIME_UNIT_CYCLES   = (`PAS_CLK_HZ / 1000) * `PAS_TIME_UNIT_MS,
  parameter int unsigned GAIN_SETTLE_CYCLES = (`PAS_CLK_HZ / 1000) * `PAS_GAIN_SETTLE_MS
) (
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst,
  input  wire pas_pkg::pas_kind_t      i_block_kind,
  input  wire logic                    i_revision_inc,
  input  wire logic [15:0]             i_position,
  input  wire logic [15:0]             i_high_threshold,
  input  wire logic [15:0]             i_high_high_threshold,
  input  wire logic [15:0]             i_low_threshold,
  input  wire logic [15:0]             i_low_low_threshold,
  input  wire logic [15:0]             i_hysteresis,
  input  wire logic                    i_autostart,
  input  wire logic                    i_adc_overrange,
  output logic [`PAS_DIGEST_W-1:0]     o_block_alert_digest,
  output logic                         o_position_high_flag,
  output logic                         o_position_high_high_flag,
  output logic                         o_position_low_flag,
  output logic                         o_position_low_low_flag,
  output logic                         o_block_alarm,
  output logic                         o_autostart_busy,
  output logic                         o_drive_open,
  output logic                         o_drive_close,
  output logic [15:0]                  o_closing_travel_time,
  output logic [15:0]                  o_opening_travel_time,
  output logic [2:0]                   o_converter_gain
);

  // Position alarm flags
  // Identical cells per threshold keep the band rule in one place
  // Flags settle one cycle after the position moves
  logic pos_enable;
  logic flag_high;
  logic flag_high_high;
  logic flag_low;
  logic flag_low_low;

  // Position alarms exist only in the function block instance
  assign pos_enable = (i_block_kind == pas_pkg::PAS_KIND_FUNCTION);

  // High side: set at or above the threshold
  pas_hyst_flag #(.HIGH_SIDE(1'b1)) u_high (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_enable     (pos_enable),
    .i_position   (i_position),
    .i_threshold  (i_high_threshold),
    .i_hysteresis (i_hysteresis),
    .o_flag       (flag_high)
  );

  pas_hyst_flag #(.HIGH_SIDE(1'b1)) u_high_high (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_enable     (pos_enable),
    .i_position   (i_position),
    .i_threshold  (i_high_high_threshold),
    .i_hysteresis (i_hysteresis),
    .o_flag       (flag_high_high)
  );

  // Low side: set at or below the threshold
  pas_hyst_flag #(.HIGH_SIDE(1'b0)) u_low (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_enable     (pos_enable),
    .i_position   (i_position),
    .i_threshold  (i_low_threshold),
    .i_hysteresis (i_hysteresis),
    .o_flag       (flag_low)
  );

  pas_hyst_flag #(.HIGH_SIDE(1'b0)) u_low_low (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_enable     (pos_enable),
    .i_position   (i_position),
    .i_threshold  (i_low_low_threshold),
    .i_hysteresis (i_hysteresis),
    .o_flag       (flag_low_low)
  );

  // Block alarm with self-clearing timer
  // Counts plain clock cycles, so the hold time tracks the clock rate
  // A 32-bit counter covers the ten-second hold at the full clock rate
  logic        blk_q;
  logic        blk_d;
  logic [31:0] blk_cnt_q;
  logic [31:0] blk_cnt_d;

  // New increment wins over the timeout and restarts the full delay
  always_comb begin
    blk_d     = blk_q;
    blk_cnt_d = blk_cnt_q;
    if (i_revision_inc) begin
      blk_d     = 1'b1;
      blk_cnt_d = 32'h0000_0000;
    end else if (blk_q) begin
      if (blk_cnt_q == BLOCK_ALARM_CYCLES - 32'h0000_0001) begin
        blk_d     = 1'b0;
        blk_cnt_d = 32'h0000_0000;
      end else begin
        blk_cnt_d = blk_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Alarm bit and its hold counter
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      blk_q     <= 1'b0;
      blk_cnt_q <= 32'h0000_0000;
    end else begin
      blk_q     <= blk_d;
      blk_cnt_q <= blk_cnt_d;
    end
  end

  // Summary word
  // Registered as a whole so a reader never sees a half-updated byte
  // Costs one extra cycle of latency against the flag outputs
  logic [`PAS_DIGEST_W-1:0] digest_q;
  logic [`PAS_DIGEST_W-1:0] digest_d;
  logic [7:0]               byte_one;

  // Reserved bits and elements stay zero; lags the flags by one cycle
  always_comb begin
    byte_one                       = 8'h00;
    byte_one[`PAS_BIT_BLOCK_ALARM] = blk_q;
    byte_one[`PAS_BIT_POS_LOW]     = flag_low;
    byte_one[`PAS_BIT_POS_LOLO]    = flag_low_low;
    byte_one[`PAS_BIT_POS_HIGH]    = flag_high;
    byte_one[`PAS_BIT_POS_HIHI]    = flag_high_high;
    digest_d = {byte_one, 8'h00, 48'h0000_0000_0000};
  end

  // Summary register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      digest_q <= `PAS_RST_DIGEST;
    end else begin
      digest_q <= digest_d;
    end
  end

  // Autostart: gain search, then opening and closing stroke timing
  // Times assume the stem really moves; a stuck valve saturates
  // the timer rather than hanging the sequence
  // Sequencer state, timers and captured results
  pas_pkg::pas_state_t st_q;
  pas_pkg::pas_state_t st_d;
  logic [31:0]         wait_q;
  logic [31:0]         wait_d;
  logic [31:0]         unit_q;
  logic [31:0]         unit_d;
  logic [15:0]         elapsed_q;
  logic [15:0]         elapsed_d;
  logic [15:0]         target_q;
  logic [15:0]         target_d;
  logic [15:0]         close_q;
  logic [15:0]         close_d;
  logic [15:0]         open_q;
  logic [15:0]         open_d;
  logic [2:0]          gain_q;
  logic [2:0]          gain_d;
  logic [24:0]         span;
  logic                unit_tick;

  // Time base in 10 ms units; a run that saturates stores the maximum
  assign unit_tick = (unit_q == TIME_UNIT_CYCLES - 32'h0000_0001);

  // Sequencer next state and capture of results
  always_comb begin
    st_d      = st_q;
    wait_d    = wait_q;
    unit_d    = unit_tick ? 32'h0000_0000 : unit_q + 32'h0000_0001;
    elapsed_d = elapsed_q;
    target_d  = target_q;
    close_d   = close_q;
    open_d    = open_q;
    gain_d    = gain_q;
    span      = 25'h0000000;
    unique case (st_q)
      pas_pkg::PAS_ST_IDLE: begin
        if (i_autostart) begin
          gain_d = `PAS_GAIN_MAX;
          wait_d = 32'h0000_0000;
          st_d   = pas_pkg::PAS_ST_GAIN_WAIT;
        end
      end
      // Let the converter settle before judging the range
      pas_pkg::PAS_ST_GAIN_WAIT: begin
        if (wait_q == GAIN_SETTLE_CYCLES - 32'h0000_0001) begin
          st_d = pas_pkg::PAS_ST_GAIN_STEP;
        end else begin
          wait_d = wait_q + 32'h0000_0001;
        end
      end
      // Step gain down until the converter is no longer over range
      pas_pkg::PAS_ST_GAIN_STEP: begin
        wait_d = 32'h0000_0000;
        if (i_adc_overrange && (gain_q != `PAS_RST_GAIN)) begin
          gain_d = gain_q - 3'h1;
          st_d   = pas_pkg::PAS_ST_GAIN_WAIT;
        end else begin
          span      = ({9'h000, `PAS_POS_FULL - i_position} * `PAS_T63_NUM) >> `PAS_T63_SHIFT;
          target_d  = i_position + span[15:0];
          elapsed_d = `PAS_RST_TIME;
          unit_d    = 32'h0000_0000;
          st_d      = pas_pkg::PAS_ST_OPEN_RUN;
        end
      end
      pas_pkg::PAS_ST_OPEN_RUN: begin
        if (i_position >= target_q || elapsed_q == `PAS_TIME_SAT) begin
          open_d    = elapsed_q;
          span      = ({9'h000, i_position} * `PAS_T63_NUM) >> `PAS_T63_SHIFT;
          target_d  = i_position - span[15:0];
          elapsed_d = `PAS_RST_TIME;
          unit_d    = 32'h0000_0000;
          st_d      = pas_pkg::PAS_ST_CLOSE_RUN;
        end else if (unit_tick) begin
          elapsed_d = elapsed_q + 16'h0001;
        end
      end
      pas_pkg::PAS_ST_CLOSE_RUN: begin
        if (i_position <= target_q || elapsed_q == `PAS_TIME_SAT) begin
          close_d = elapsed_q;
          st_d    = pas_pkg::PAS_ST_IDLE;
        end else if (unit_tick) begin
          elapsed_d = elapsed_q + 16'h0001;
        end
      end
      default: begin
        st_d = pas_pkg::PAS_ST_IDLE;
      end
    endcase
  end

  // Results and gain are held until the next autostart
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q      <= pas_pkg::PAS_ST_IDLE;
      wait_q    <= 32'h0000_0000;
      unit_q    <= 32'h0000_0000;
      elapsed_q <= `PAS_RST_TIME;
      target_q  <= `PAS_POS_ZERO;
      close_q   <= `PAS_RST_TIME;
      open_q    <= `PAS_RST_TIME;
      gain_q    <= `PAS_RST_GAIN;
    end else begin
      st_q      <= st_d;
      wait_q    <= wait_d;
      unit_q    <= unit_d;
      elapsed_q <= elapsed_d;
      target_q  <= target_d;
      close_q   <= close_d;
      open_q    <= open_d;
      gain_q    <= gain_d;
    end
  end

  // Outputs
  // Data outputs come straight from registers
  // Drive and busy lines are decoded from the state register
  assign o_block_alert_digest      = digest_q;
  assign o_position_high_flag      = flag_high;
  assign o_position_high_high_flag = flag_high_high;
  assign o_position_low_flag       = flag_low;
  assign o_position_low_low_flag   = flag_low_low;
  assign o_block_alarm             = blk_q;

  // Decoded status, combinational by design
  assign o_autostart_busy          = (st_q != pas_pkg::PAS_ST_IDLE);
  assign o_drive_open              = (st_q == pas_pkg::PAS_ST_OPEN_RUN);
  assign o_drive_close             = (st_q == pas_pkg::PAS_ST_CLOSE_RUN);
  assign o_closing_travel_time     = close_q;
  assign o_opening_travel_time     = open_q;
  assign o_converter_gain          = gain_q;

endmodule

`default_nettype wire

//--- test/pas_alarm_summary_props.sv
// Assertion checker bound to the positioner alarm summary block
`timescale 1ns/10ps
`default_nettype none
module pas_alarm_summary_props #(
  parameter int unsigned BLOCK_ALARM_CYCLES = 50
) (
  input wire logic               i_mclk,
  input wire logic               i_rst,
  input wire pas_pkg::pas_kind_t i_block_kind,
  input wire logic               i_revision_inc,
  input wire logic [15:0]        i_position,
  input wire logic [15:0]        i_high_high_threshold,
  input wire logic [15:0]        i_low_low_threshold,
  input wire logic [15:0]        i_hysteresis,
  input wire logic               i_autostart,
  input wire logic [63:0]        o_block_alert_digest,
  input wire logic               o_position_high_flag,
  input wire logic               o_position_high_high_flag,
  input wire logic               o_position_low_flag,
  input wire logic               o_position_low_low_flag,
  input wire logic               o_block_alarm,
  input wire logic               o_autostart_busy,
  input wire logic               o_drive_open,
  input wire logic               o_drive_close,
  input wire logic [2:0]         o_converter_gain
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [31:0] since_q;
  logic [31:0] since_d;
  logic        func;
  assign func = i_block_kind == pas_pkg::PAS_KIND_FUNCTION;
  // Cycles since the last revision pulse, saturating once past the hold time
  always_comb begin
    since_d = since_q;
    if (i_revision_inc) since_d = 32'h1;
    else if (since_q <= BLOCK_ALARM_CYCLES) since_d = since_q + 32'h1;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) since_q <= 32'(BLOCK_ALARM_CYCLES + 1);
    else since_q <= since_d;
  end
  elem_rsv_a: assert property (o_block_alert_digest[55:0] == 56'h0)
    else $error("reserved summary bits not zero");
  byte_rsv_a: assert property ({o_block_alert_digest[62:61], o_block_alert_digest[56]} == 3'h0)
    else $error("reserved status bits not zero");
  bit_map_a: assert property (o_block_alert_digest[63:57] == {$past(o_block_alarm), 2'h0,
    $past(o_position_low_flag), $past(o_position_low_low_flag), $past(o_position_high_flag),
    $past(o_position_high_high_flag)}) else $error("summary bit map wrong");
  kind_zero_a: assert property (!func |=> {o_position_low_flag, o_position_low_low_flag,
    o_position_high_flag, o_position_high_high_flag} == 4'h0) else $error("flag outside function kind");
  hihi_set_a: assert property (func && i_position >= i_high_high_threshold |=> o_position_high_high_flag)
    else $error("high-high flag not set");
  lolo_set_a: assert property (func && i_position <= i_low_low_threshold |=> o_position_low_low_flag)
    else $error("low-low flag not set");
  hihi_clr_a: assert property (17'(i_position) + 17'(i_hysteresis) < 17'(i_high_high_threshold)
    |=> !o_position_high_high_flag) else $error("high-high flag not cleared");
  lolo_clr_a: assert property (17'(i_position) > 17'(i_low_low_threshold) + 17'(i_hysteresis)
    |=> !o_position_low_low_flag) else $error("low-low flag not cleared");
  alarm_set_a: assert property (i_revision_inc |=> o_block_alarm ##1 o_block_alert_digest[63])
    else $error("block alarm not raised");
  alarm_time_a: assert property (o_block_alarm == (since_q <= BLOCK_ALARM_CYCLES))
    else $error("block alarm hold time wrong");
  start_gain_a: assert property (!o_autostart_busy && i_autostart |=> o_autostart_busy && o_converter_gain == 3'h7)
    else $error("autostart did not start");
  gain_keep_a: assert property (!o_autostart_busy ##1 !o_autostart_busy |-> $stable(o_converter_gain))
    else $error("gain changed while idle");
  drive_ok_a: assert property (o_drive_open || o_drive_close |-> o_autostart_busy && !(o_drive_open && o_drive_close))
    else $error("drive outputs wrong");
  // Main scenarios reached
  cover property (o_block_alarm ##1 !o_block_alarm);
  cover property ($fell(o_autostart_busy));
  cover property (o_position_high_high_flag && o_position_high_flag);
endmodule
bind pas_alarm_summary pas_alarm_summary_props #(.BLOCK_ALARM_CYCLES(BLOCK_ALARM_CYCLES)) u_props (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_block_kind(i_block_kind), .i_revision_inc(i_revision_inc),
  .i_position(i_position), .i_high_high_threshold(i_high_high_threshold),
  .i_low_low_threshold(i_low_low_threshold), .i_hysteresis(i_hysteresis), .i_autostart(i_autostart),
  .o_block_alert_digest(o_block_alert_digest), .o_position_high_flag(o_position_high_flag),
  .o_position_high_high_flag(o_position_high_high_flag), .o_position_low_flag(o_position_low_flag),
  .o_position_low_low_flag(o_position_low_low_flag), .o_block_alarm(o_block_alarm),
  .o_autostart_busy(o_autostart_busy), .o_drive_open(o_drive_open), .o_drive_close(o_drive_close),
  .o_converter_gain(o_converter_gain)
);
`default_nettype wire

//--- test/pas_valve_model.sv
// Valve and converter model answering the autostart drive outputs
`timescale 1ns/10ps
`default_nettype none
module pas_valve_model #(
  parameter logic [2:0] OVR_GAIN = 3'h5
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_drive_open,
  input  wire logic        i_drive_close,
  input  wire logic [2:0]  i_gain,
  input  wire logic [15:0] i_step,
  output logic [15:0]      o_position,
  output logic             o_overrange
);
  // Converter clips above this gain, so the search has to step down
  assign o_overrange = i_gain > OVR_GAIN;
  // Stem moves a fixed step per cycle, clamped at both ends
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_position <= 16'h0000;
    else if (i_drive_open)
      o_position <= (o_position > 16'h2710 - i_step) ? 16'h2710 : o_position + i_step;
    else if (i_drive_close)
      o_position <= (o_position < i_step) ? 16'h0000 : o_position - i_step;
  end
endmodule
`default_nettype wire

//--- test/test_pas_alarm_summary.sv
// Self-checking bench for the positioner alarm summary block
`timescale 1ns/10ps
`default_nettype none
module test_pas_alarm_summary;
  localparam int unsigned N_BA = 50;
  logic               i_mclk = 1'b0;
  logic               i_rst = 1'b1;
  pas_pkg::pas_kind_t kind = pas_pkg::PAS_KIND_FUNCTION;
  logic               rev_inc = 1'b0;
  logic               start = 1'b0;
  logic               use_model = 1'b0;
  logic [15:0]        pos_tb = 16'h1388;
  logic [15:0]        step = 16'h0064;
  logic [15:0]        hyst = 16'h00C8;
  logic [15:0]        thr_hh = 16'h2328;
  logic [15:0]        thr_ll = 16'h03E8;
  logic [15:0]        mpos, pos, t_open, t_close;
  logic [63:0]        digest;
  logic               f_hi, f_hh, f_lo, f_ll, alarm, busy, d_open, d_close, ovr;
  logic [2:0]         gain;
  int                 num_errors = 0;
  int                 n_checks = 0;
  int                 p0, e_open, e_close;
  // Rows: kind, position, expected {low, low-low, high, high-high}
  logic [21:0] rows [12] = '{{2'h0, 16'h1388, 4'h0}, {2'h0, 16'h2328, 4'h3}, {2'h0, 16'h2292, 4'h3},
    {2'h0, 16'h2256, 4'h2}, {2'h0, 16'h1E14, 4'h0}, {2'h0, 16'h03E8, 4'hC}, {2'h0, 16'h047E, 4'hC},
    {2'h0, 16'h04E2, 4'h8}, {2'h0, 16'h08FC, 4'h0}, {2'h1, 16'h251C, 4'h0}, {2'h2, 16'h01F4, 4'h0},
    {2'h0, 16'h01F4, 4'hC}};
  // Position comes from the valve model from the calibration runs onward
  assign pos = use_model ? mpos : pos_tb;
  pas_alarm_summary #(.BLOCK_ALARM_CYCLES(N_BA), .TIME_UNIT_CYCLES(4), .GAIN_SETTLE_CYCLES(3)) uut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_block_kind(kind), .i_revision_inc(rev_inc), .i_position(pos),
    .i_high_threshold(16'h1F40), .i_high_high_threshold(thr_hh), .i_low_threshold(16'h07D0),
    .i_low_low_threshold(thr_ll), .i_hysteresis(hyst), .i_autostart(start), .i_adc_overrange(ovr),
    .o_block_alert_digest(digest), .o_position_high_flag(f_hi), .o_position_high_high_flag(f_hh),
    .o_position_low_flag(f_lo), .o_position_low_low_flag(f_ll), .o_block_alarm(alarm),
    .o_autostart_busy(busy), .o_drive_open(d_open), .o_drive_close(d_close),
    .o_closing_travel_time(t_close), .o_opening_travel_time(t_open), .o_converter_gain(gain));
  pas_valve_model valve (.i_mclk(i_mclk), .i_rst(i_rst), .i_drive_open(d_open), .i_drive_close(d_close),
    .i_gain(gain), .i_step(step), .o_position(mpos), .o_overrange(ovr));
  initial forever #5 i_mclk = ~i_mclk;
  task automatic nclk(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    nclk(20);
    i_rst = 1'b0;
    check(digest, 64'h0);
    check({gain, t_open, t_close}, 64'h0);
    foreach (rows[i]) begin
      kind = pas_pkg::pas_kind_t'(rows[i][21:20]);
      pos_tb = rows[i][19:4];
      nclk(3);
      check({f_lo, f_ll, f_hi, f_hh}, rows[i][3:0]);
      check(digest[60:57], rows[i][3:0]);
    end
    // Zero band and moved thresholds: flags follow the condition exactly
    hyst = 16'h0000;
    thr_hh = 16'h1F40;
    thr_ll = 16'h0100;
    pos_tb = 16'h1F40;
    nclk(2);
    check({f_lo, f_ll, f_hi, f_hh}, 4'h3);
    pos_tb = 16'h1F3F;
    nclk(2);
    check({f_hi, f_hh}, 2'h0);
    pos_tb = 16'h0100;
    nclk(2);
    check({f_lo, f_ll}, 2'h3);
    pos_tb = 16'h0101;
    nclk(2);
    check({f_lo, f_ll}, 2'h2);
    $display("flag table done");
    // Single pulse, then a back-to-back pair that must restart the count
    rev_inc = 1'b1;
    nclk(1);
    rev_inc = 1'b0;
    check(alarm, 1'b1);
    nclk(29);
    rev_inc = 1'b1;
    nclk(2);
    rev_inc = 1'b0;
    check(digest[63], 1'b1);
    nclk(N_BA - 1);
    check(alarm, 1'b1);
    nclk(1);
    check(alarm, 1'b0);
    $display("block alarm done");
    // Two calibration runs, fast and slow valve; times within a few ticks
    kind = pas_pkg::PAS_KIND_FUNCTION;
    use_model = 1'b1;
    for (int k = 0; k < 2; k++) begin
      step = k ? 16'h0032 : 16'h0064;
      p0 = mpos;
      e_open = (161 * (10000 - p0) / 256) / step / 4;
      start = 1'b1;
      nclk(1);
      start = 1'b0;
      check(busy, 1'b1);
      for (int w = 0; w < 3000 && d_open !== 1'b1; w++) nclk(1);
      check({d_open, d_close, gain}, 5'h15);
      for (int w = 0; w < 3000 && d_close !== 1'b1; w++) nclk(1);
      check({d_open, d_close}, 2'h1);
      e_close = (161 * mpos / 256) / step / 4;
      for (int w = 0; w < 3000 && busy !== 1'b0; w++) nclk(1);
      check(busy, 1'b0);
      check(gain, 3'h5);
      check(t_open + 3 >= e_open && t_open <= e_open + 3, 1'b1);
      check(t_close + 3 >= e_close && t_close <= e_close + 3, 1'b1);
    end
    $display("autostart done");
    // Reset in mid-alarm clears alarm, gain, opening time and digest bit 63
    rev_inc = 1'b1;
    nclk(1);
    rev_inc = 1'b0;
    i_rst = 1'b1;
    nclk(2);
    i_rst = 1'b0;
    check({alarm, gain, t_open, digest[63]}, 64'h0);
    $display("reset done");
    complete_run();
  end
endmodule
`default_nettype wire
